/* fig_ecc_codec.sv */
// Hamming single-error-correcting codec: 32 data bits protected by 6 check bits at positions 1, 2, 4, 8, 16, 32.
// A syndrome that points past the last code position marks the word as uncorrectable.
// Assumes combinational use; the guard registers rd_data and rd_unc but drives wr_chk straight to the flash.
`timescale 1ns/100ps
module fig_ecc_codec
  import fig_pkg::*;
(
  fig_ecc_if.codec e
);
  function automatic logic [38:0] spread(input logic [31:0] d);
    logic [38:0] c;
    int          k;
    c = '0;
    k = 0;
    for (int p = 1; p < 39; p++) begin
      if ((p & (p - 1)) != 0) begin
        c[p] = d[k];
        k++;
      end
    end
    return c;
  endfunction : spread

  function automatic logic [5:0] synd(input logic [38:0] c);
    logic [5:0] s;
    s = '0;
    for (int p = 1; p < 39; p++) begin
      for (int b = 0; b < 6; b++) begin
        if (p[b]) begin
          s[b] = s[b] ^ c[p];
        end
      end
    end
    return s;
  endfunction : synd

  function automatic logic [31:0] gather(input logic [38:0] c);
    logic [31:0] d;
    int          k;
    d = '0;
    k = 0;
    for (int p = 1; p < 39; p++) begin
      if ((p & (p - 1)) != 0) begin
        d[k] = c[p];
        k++;
      end
    end
    return d;
  endfunction : gather

  logic [38:0] wr_pos;
  logic [38:0] rd_pos;
  logic [38:0] fix_pos;
  logic [5:0]  rd_syn;
  logic        rd_fix;

  // Check bit b sits at code position 2**b, so the syndrome of a clean word is zero.
  always_comb begin
    wr_pos   = spread(e.wr_data);
    e.wr_chk = synd(wr_pos);
  end

  always_comb begin
    rd_pos = spread(e.rd_code[DATA_W-1:0]);
    for (int b = 0; b < CHK_W; b++) begin
      rd_pos[1 << b] = e.rd_code[DATA_W+b];
    end
    rd_syn  = synd(rd_pos);
    rd_fix  = (rd_syn != 6'h00) && (rd_syn <= CHK_W'(CODE_W));
    fix_pos = rd_pos;
    if (rd_fix) begin
      fix_pos[rd_syn] = ~rd_pos[rd_syn];
    end
    e.rd_data = gather(fix_pos);
    e.rd_corr = rd_fix;
    e.rd_unc  = (rd_syn > CHK_W'(CODE_W));
  end
endmodule : fig_ecc_codec

/* fig_ecc_if.sv */
// Interface carrying one protected word between the guard and its ECC codec.
// Assumes purely combinational use inside one clock domain.
`timescale 1ns/100ps
interface fig_ecc_if;
  import fig_pkg::*;
  logic [DATA_W-1:0] wr_data;
  logic [CHK_W-1:0]  wr_chk;
  logic [CODE_W-1:0] rd_code;
  logic [DATA_W-1:0] rd_data;
  logic              rd_corr;
  logic              rd_unc;
  modport guard (output wr_data, rd_code, input wr_chk, rd_data, rd_corr, rd_unc);
  modport codec (input wr_data, rd_code, output wr_chk, rd_data, rd_corr, rd_unc);
endinterface : fig_ecc_if

/* fig_flash_model.sv */
// Behavioural data flash array that answers the guard's flash port.
// Assumes the guard samples read data in the cycle after its read strobe.
`timescale 1ns/100ps
module fig_flash_model
  import fig_pkg::*;
(
  input  wire logic                       clk_i,
  input  wire logic [fig_pkg::ADDR_W-1:0] fl_addr_i,
  input  wire logic                       fl_rd_i,
  input  wire logic                       fl_wr_i,
  input  wire logic [fig_pkg::CODE_W-1:0] fl_wdata_i,
  output logic      [fig_pkg::CODE_W-1:0] fl_rdata_o
);
  logic [CODE_W-1:0] mem [0:(1<<ADDR_W)-1];

  initial begin
    for (int i = 0; i < (1 << ADDR_W); i++) begin
      mem[i] = '0;
    end
    fl_rdata_o = '0;
  end

  // Outside a read the data lines toggle, so a stale word is never taken for an answer.
  always @(posedge clk_i) begin
    if (fl_wr_i) begin
      mem[fl_addr_i] <= fl_wdata_i;
    end
    if (fl_rd_i) begin
      fl_rdata_o <= mem[fl_addr_i];
    end else begin
      fl_rdata_o <= ~fl_rdata_o;
    end
  end
endmodule : fig_flash_model

/* fig_guard.sv */
// Power-up integrity checks, watchdog reset, parameter range check and flash ECC path.
// Assumes the flash array answers reads in the next cycle and golden sums are inputs.
`timescale 1ns/100ps
module fig_guard
  import fig_pkg::*;
(
  input  wire logic                       clk_i,
  input  wire logic                       reset_n_i,
  input  wire logic [fig_pkg::ADDR_W-1:0] prog_end_i,
  input  wire logic [fig_pkg::ADDR_W-1:0] cfg_end_i,
  input  wire logic [fig_pkg::ADDR_W-1:0] log_end_i,
  input  wire logic [fig_pkg::SUM_W-1:0]  prog_sum_i,
  input  wire logic [fig_pkg::SUM_W-1:0]  cfg_sum_i,
  input  wire logic [fig_pkg::SUM_W-1:0]  log_sum_i,
  output logic      [fig_pkg::ADDR_W-1:0] fl_addr_o,
  output logic                            fl_rd_o,
  output logic                            fl_wr_o,
  output logic      [fig_pkg::CODE_W-1:0] fl_wdata_o,
  input  wire logic [fig_pkg::CODE_W-1:0] fl_rdata_i,
  input  wire logic                       host_wr_i,
  input  wire logic [fig_pkg::ADDR_W-1:0] host_addr_i,
  input  wire logic [fig_pkg::DATA_W-1:0] host_wdata_i,
  output logic      [fig_pkg::DATA_W-1:0] host_rdata_o,
  output logic                            host_rvalid_o,
  output logic                            host_rd_unc_o,
  input  wire logic                       cfg_wr_i,
  input  wire logic [fig_pkg::CFG_W-1:0]  cfg_val_i,
  output logic      [fig_pkg::CFG_W-1:0]  cfg_val_o,
  output logic                            cfg_reject_o,
  input  wire logic                       wdog_kick_i,
  output logic                            run_o,
  output logic                            bus_ready_o,
  output logic                            host_alert_out_n_o,
  output logic      [fig_pkg::ST_W-1:0]   status_o,
  output logic      [fig_pkg::GPIO_W-1:0] gpio_oe_o,
  output logic      [fig_pkg::PWM_W-1:0]  fast_pulse_output_o,
  input  wire logic [fig_pkg::GPIO_W-1:0] gpio_oe_req_i,
  input  wire logic [fig_pkg::PWM_W-1:0]  fast_pulse_req_i
);
  import fig_pkg::*;

  typedef enum logic [2:0] {FIG_HOLD, FIG_SCAN, FIG_RUN, FIG_HALT} fig_state_t;

  fig_ecc_if ecc ();
  fig_ecc_codec u_codec (.e(ecc));

  fig_state_t        state_ff, nxt_state;
  logic [1:0]        region_ff, nxt_region;
  logic [ADDR_W-1:0] addr_ff, nxt_addr;
  logic [SUM_W-1:0]  sum_ff, nxt_sum;
  logic              rd_pend_ff, nxt_rd_pend;
  logic              last_ff, nxt_last;
  logic [ST_W-1:0]   status_ff, nxt_status;
  logic [CFG_W-1:0]  cfg_ff, nxt_cfg;
  logic              reject_ff, nxt_reject;
  logic [WDOG_W-1:0] wdog_ff, nxt_wdog;
  logic [RST_W-1:0]  hold_ff, nxt_hold;
  logic              hrd_ff, nxt_hrd;
  logic [DATA_W-1:0] hdata_ff, nxt_hdata;
  logic              hunc_ff, nxt_hunc;
  logic              hreq_ff, nxt_hreq;
  logic              wdog_fire;
  logic [ADDR_W-1:0] region_end;
  logic [SUM_W-1:0]  region_sum;

  assign wdog_fire = (state_ff == FIG_RUN) && (wdog_ff == WDOG_W'(WDOG_CYC - 1));

  always_comb begin
    unique case (region_ff)
      REG_PROG: begin
        region_end = prog_end_i;
        region_sum = prog_sum_i;
      end
      REG_CFG: begin
        region_end = cfg_end_i;
        region_sum = cfg_sum_i;
      end
      default: begin
        region_end = log_end_i;
        region_sum = log_sum_i;
      end
    endcase
  end

  // Power-up scan walks program, configuration and log regions in turn.
  always_comb begin
    nxt_state   = state_ff;
    nxt_region  = region_ff;
    nxt_addr    = addr_ff;
    nxt_sum     = sum_ff;
    nxt_rd_pend = 1'b0;
    nxt_last    = last_ff;
    nxt_status  = status_ff;
    nxt_cfg     = cfg_ff;
    nxt_hold    = hold_ff;
    unique case (state_ff)
      FIG_HOLD: begin
        nxt_hold = hold_ff + RST_W'(1);
        if (hold_ff == RST_W'(RST_HOLD_CYC - 1)) begin
          nxt_state  = FIG_SCAN;
          nxt_region = REG_PROG;
          nxt_addr   = '0;
          nxt_sum    = SUM_INIT;
          nxt_last   = 1'b0;
          nxt_hold   = '0;
        end
      end
      FIG_SCAN: begin
        if (!rd_pend_ff && !last_ff) begin
          nxt_rd_pend = 1'b1;
        end else if (rd_pend_ff) begin
          nxt_sum  = sum_ff + ecc.rd_data[SUM_W-1:0] + ecc.rd_data[DATA_W-1:SUM_W];
          nxt_last = (addr_ff == region_end);
          nxt_addr = addr_ff + ADDR_W'(1);
          // The first configuration word carries the stored setting; a bad sum replaces it later.
          if (region_ff == REG_CFG && addr_ff == prog_end_i + ADDR_W'(1)) begin
            nxt_cfg = ecc.rd_data[CFG_W-1:0];
          end
          if (ecc.rd_unc) begin
            nxt_status[ST_ECC_UNC] = 1'b1;
          end
        end else begin
          nxt_sum  = SUM_INIT;
          nxt_last = 1'b0;
          unique case (region_ff)
            REG_PROG: begin
              nxt_status[ST_PROG_ERR] = (sum_ff != region_sum);
              nxt_region = REG_CFG;
              nxt_addr   = prog_end_i + ADDR_W'(1);
            end
            REG_CFG: begin
              if (sum_ff != region_sum) begin
                nxt_status[ST_CFG_ERR] = 1'b1;
                nxt_cfg = CFG_DFLT;
              end
              nxt_region = REG_LOG;
              nxt_addr   = cfg_end_i + ADDR_W'(1);
            end
            default: begin
              nxt_status[ST_LOG_ERR] = (sum_ff != region_sum);
              nxt_state = status_ff[ST_PROG_ERR] ? FIG_HALT : FIG_RUN;
            end
          endcase
        end
      end
      FIG_RUN: begin
        if (wdog_fire) begin
          nxt_state  = FIG_HOLD;
          nxt_status = '0;
          nxt_cfg    = CFG_DFLT;
        end
      end
      FIG_HALT: begin
        nxt_state = FIG_HALT;
      end
      default: nxt_state = FIG_HOLD;
    endcase
    if (state_ff == FIG_RUN && !wdog_fire && cfg_wr_i && cfg_val_i >= CFG_MIN && cfg_val_i <= CFG_MAX) begin
      nxt_cfg = cfg_val_i;
    end
  end

  always_comb begin
    nxt_wdog = '0;
    if (state_ff == FIG_RUN && !wdog_kick_i && !wdog_fire) begin
      nxt_wdog = wdog_ff + WDOG_W'(1);
    end
    nxt_reject = cfg_wr_i && (state_ff != FIG_RUN || wdog_fire ||
                              cfg_val_i < CFG_MIN || cfg_val_i > CFG_MAX);
    // A host read answer is valid two cycles after its strobe: one for the array, one for this register.
    nxt_hreq   = fl_rd_o && (state_ff != FIG_SCAN);
    nxt_hrd    = hreq_ff;
    nxt_hdata  = ecc.rd_unc ? '0 : ecc.rd_data;
    nxt_hunc   = ecc.rd_unc;
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_ff   <= FIG_HOLD;
      region_ff  <= REG_PROG;
      addr_ff    <= '0;
      sum_ff     <= SUM_INIT;
      rd_pend_ff <= 1'b0;
      last_ff    <= 1'b0;
      status_ff  <= '0;
      cfg_ff     <= CFG_DFLT;
      reject_ff  <= 1'b0;
      wdog_ff    <= '0;
      hold_ff    <= '0;
      hrd_ff     <= 1'b0;
      hdata_ff   <= '0;
      hunc_ff    <= 1'b0;
      hreq_ff    <= 1'b0;
    end else begin
      state_ff   <= nxt_state;
      region_ff  <= nxt_region;
      addr_ff    <= nxt_addr;
      sum_ff     <= nxt_sum;
      rd_pend_ff <= nxt_rd_pend;
      last_ff    <= nxt_last;
      status_ff  <= nxt_status;
      cfg_ff     <= nxt_cfg;
      reject_ff  <= nxt_reject;
      wdog_ff    <= nxt_wdog;
      hold_ff    <= nxt_hold;
      hrd_ff     <= nxt_hrd;
      hdata_ff   <= nxt_hdata;
      hunc_ff    <= nxt_hunc;
      hreq_ff    <= nxt_hreq;
    end
  end

  // Flash port: scan reads own it; otherwise, once bus_ready_o is high, the host reads or writes encoded words.
  assign ecc.wr_data          = host_wdata_i;
  assign ecc.rd_code          = fl_rdata_i;
  assign fl_rd_o              = (state_ff == FIG_SCAN) ? nxt_rd_pend : !host_wr_i && bus_ready_o;
  assign fl_wr_o              = host_wr_i && bus_ready_o;
  assign fl_addr_o            = (state_ff == FIG_SCAN) ? addr_ff : host_addr_i;
  assign fl_wdata_o           = {ecc.wr_chk, host_wdata_i};
  assign bus_ready_o          = (state_ff == FIG_RUN) || (state_ff == FIG_HALT);
  assign run_o                = (state_ff == FIG_RUN);
  assign host_alert_out_n_o   = !status_ff[ST_CFG_ERR];
  assign status_o             = status_ff;
  assign cfg_val_o            = cfg_ff;
  assign cfg_reject_o         = reject_ff;
  assign host_rdata_o         = hdata_ff;
  assign host_rvalid_o        = hrd_ff;
  assign host_rd_unc_o        = hunc_ff;
  assign gpio_oe_o            = run_o ? gpio_oe_req_i : '0;
  assign fast_pulse_output_o  = run_o ? fast_pulse_req_i : '0;

  // Assertions.
  halt_never_runs_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    state_ff == FIG_HALT |=> !run_o && bus_ready_o) else $error("Halted device ran program.");
  run_needs_prog_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    $rose(run_o) |-> !status_ff[ST_PROG_ERR]) else $error("Run started with bad program sum.");
  alert_tracks_cfg_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    $fell(host_alert_out_n_o) |-> status_o[ST_CFG_ERR] && $past(state_ff) == FIG_SCAN && $past(region_ff) == REG_CFG)
    else $error("Alert not raised by the configuration check.");
  cfg_default_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    state_ff == FIG_SCAN && $rose(status_ff[ST_CFG_ERR]) |-> cfg_ff == CFG_DFLT)
    else $error("Defaults not loaded.");
  wdog_reset_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    wdog_fire |=> state_ff == FIG_HOLD && status_ff == '0 && cfg_ff == CFG_DFLT ##1 !run_o)
    else $error("Watchdog did not reset.");
  reset_pins_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    state_ff == FIG_HOLD |-> gpio_oe_o == '0 && fast_pulse_output_o == '0) else $error("Pins driven in reset.");
  range_check_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    cfg_wr_i && cfg_val_i > CFG_MAX |=> cfg_reject_o && $stable(cfg_ff)) else $error("Out of range value taken.");
  ecc_round_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    fl_wr_o |-> fl_wdata_o == {ecc.wr_chk, host_wdata_i} && !fl_rd_o) else $error("Check bits missing.");
  unc_flag_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    hreq_ff && ecc.rd_unc |=> host_rvalid_o && host_rd_unc_o && host_rdata_o == '0)
    else $error("Uncorrectable word passed.");
  log_check_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    state_ff == FIG_SCAN && region_ff == REG_LOG && !rd_pend_ff && last_ff
    |=> status_ff[ST_LOG_ERR] == (log_sum_i != $past(sum_ff))) else $error("Log sum flag wrong.");
  run_cov: cover property (@(posedge clk_i) disable iff (!reset_n_i) $rose(run_o));
  halt_cov: cover property (@(posedge clk_i) disable iff (!reset_n_i) state_ff == FIG_HALT);
  cfg_err_cov: cover property (@(posedge clk_i) disable iff (!reset_n_i) $rose(status_ff[ST_CFG_ERR]));
  wdog_cov: cover property (@(posedge clk_i) disable iff (!reset_n_i) wdog_fire);
  ecc_fix_cov: cover property (@(posedge clk_i) disable iff (!reset_n_i) hreq_ff && ecc.rd_corr);
endmodule : fig_guard

/* fig_pkg.sv */
// Shared constants and types for the flash integrity guard.
// Assumes a single 50 MHz clock domain and an asynchronous active-low reset.
package fig_pkg;
  localparam int unsigned CLK_MHZ        = 50;
  localparam int unsigned DATA_W         = 32;
  localparam int unsigned CHK_W          = 6;
  localparam int unsigned CODE_W         = DATA_W + CHK_W;
  localparam int unsigned ADDR_W         = 12;
  localparam int unsigned SUM_W          = 16;
  localparam int unsigned GPIO_W         = 26;
  localparam int unsigned PWM_W          = 12;
  localparam int unsigned CFG_W          = 8;
  localparam int unsigned WDOG_US        = 1000;
  localparam int unsigned WDOG_CYC       = WDOG_US * CLK_MHZ;
  localparam int unsigned WDOG_W         = 24;
  localparam int unsigned RST_HOLD_CYC   = 16;
  localparam int unsigned RST_W          = 5;
  localparam logic [SUM_W-1:0] SUM_INIT  = 16'h0000;
  localparam logic [CFG_W-1:0] CFG_MAX   = 8'hc8;
  localparam logic [CFG_W-1:0] CFG_MIN   = 8'h01;
  localparam logic [CFG_W-1:0] CFG_DFLT  = 8'h10;
  localparam logic [1:0] REG_PROG        = 2'h0;
  localparam logic [1:0] REG_CFG         = 2'h1;
  localparam logic [1:0] REG_LOG         = 2'h2;
  localparam int unsigned ST_CFG_ERR     = 0;
  localparam int unsigned ST_PROG_ERR    = 1;
  localparam int unsigned ST_LOG_ERR     = 2;
  localparam int unsigned ST_ECC_UNC     = 3;
  localparam int unsigned ST_W           = 4;
endpackage : fig_pkg

/* tb.sv */
// Self-checking testbench for the flash integrity guard with a behavioural flash array.
// Assumes the package constants and the registered answer timing of the guard.
`timescale 1ns/100ps
module tb
  import fig_pkg::*;
;
  logic                clk_i, reset_n_i, host_wr_i, cfg_wr_i, wdog_kick_i;
  logic [ADDR_W-1:0]   host_addr_i, fl_addr_o;
  logic [DATA_W-1:0]   host_wdata_i, host_rdata_o;
  logic [SUM_W-1:0]    prog_sum_i, cfg_sum_i, log_sum_i;
  logic [CODE_W-1:0]   fl_wdata_o, fl_rdata_i;
  logic [CFG_W-1:0]    cfg_val_i, cfg_val_o;
  logic [ST_W-1:0]     status_o;
  logic [GPIO_W-1:0]   gpio_oe_o, gpio_oe_req_i;
  logic [PWM_W-1:0]    fast_pulse_output_o, fast_pulse_req_i;
  logic                fl_rd_o, fl_wr_o, host_rvalid_o, host_rd_unc_o, cfg_reject_o;
  logic                run_o, bus_ready_o, host_alert_out_n_o;
  int                  num_errors = 0;
  int                  num_checks = 0;

  fig_guard uut (.clk_i, .reset_n_i, .prog_end_i(12'h003), .cfg_end_i(12'h007), .log_end_i(12'h00b),
    .prog_sum_i, .cfg_sum_i, .log_sum_i, .fl_addr_o, .fl_rd_o, .fl_wr_o, .fl_wdata_o, .fl_rdata_i,
    .host_wr_i, .host_addr_i, .host_wdata_i, .host_rdata_o, .host_rvalid_o, .host_rd_unc_o,
    .cfg_wr_i, .cfg_val_i, .cfg_val_o, .cfg_reject_o, .wdog_kick_i, .run_o, .bus_ready_o,
    .host_alert_out_n_o, .status_o, .gpio_oe_o, .fast_pulse_output_o, .gpio_oe_req_i, .fast_pulse_req_i);
  fig_flash_model flash (.clk_i, .fl_addr_i(fl_addr_o), .fl_rd_i(fl_rd_o), .fl_wr_i(fl_wr_o),
    .fl_wdata_i(fl_wdata_o), .fl_rdata_o(fl_rdata_i));

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  task automatic print_verdict();
    if (num_errors == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : print_verdict

  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
    #2;
  endtask : step

  function automatic logic [DATA_W-1:0] pat(input int i);
    return 32'h5a3c_0f00 ^ (32'(i) * 32'h0011_2233);
  endfunction : pat

  function automatic logic [SUM_W-1:0] rsum(input int lo, input int hi);
    logic [SUM_W-1:0]  s;
    logic [DATA_W-1:0] w;
    s = SUM_INIT;
    for (int i = lo; i <= hi; i++) begin
      w = pat(i);
      s = s + w[15:0] + w[31:16];
    end
    return s;
  endfunction : rsum

  task automatic boot(input logic [SUM_W-1:0] ps, input logic [SUM_W-1:0] cs, input logic [SUM_W-1:0] ls);
    int n;
    prog_sum_i = ps;
    cfg_sum_i = cs;
    log_sum_i = ls;
    reset_n_i = 1'b0;
    step(2);
    check("pins_in_reset", {gpio_oe_o, fast_pulse_output_o}, '0);
    check("alert_in_reset", host_alert_out_n_o, 1'b1);
    reset_n_i = 1'b1;
    step(1);
    check("pins_in_hold", {gpio_oe_o, fast_pulse_output_o}, '0);
    check("run_in_hold", run_o, 1'b0);
    n = 0;
    while (bus_ready_o !== 1'b1 && n < 500) begin
      step(1);
      n++;
    end
    if (n == 500) begin
      num_errors++;
      print_verdict();
    end
  endtask : boot

  task automatic host_read(input int a, output logic [DATA_W-1:0] d, output logic u);
    host_addr_i = ADDR_W'(a);
    step(2);
    d = host_rdata_o;
    u = host_rd_unc_o;
    check("rd_valid", host_rvalid_o, 1'b1);
  endtask : host_read

  task automatic t_halt();
    boot(~rsum(0, 3), rsum(4, 7), rsum(8, 11));
    check("halt_run", run_o, 1'b0);
    check("halt_bus", bus_ready_o, 1'b1);
    check("halt_flag", status_o[ST_PROG_ERR], 1'b1);
    cfg_wr_i = 1'b1;
    cfg_val_i = 8'h20;
    step(1);
    cfg_wr_i = 1'b0;
    check("halt_cfg_refused", cfg_reject_o, 1'b1);
    host_wr_i = 1'b1;
    for (int i = 0; i < 12; i++) begin
      host_addr_i = ADDR_W'(i);
      host_wdata_i = pat(i);
      #1;
      check("wr_strobe", fl_wr_o, 1'b1);
      check("wr_data", fl_wdata_o[DATA_W-1:0], pat(i));
      if (i >= 2) begin
        check("wr_no_rvalid", host_rvalid_o, 1'b0);
      end
      step(1);
    end
    host_wr_i = 1'b0;
  endtask : t_halt

  task automatic t_ecc();
    logic [DATA_W-1:0] d;
    logic              u;
    for (int i = 0; i < 12; i++) begin
      host_read(i, d, u);
      check("rd_data", d, pat(i));
      check("rd_unc", u, 1'b0);
    end
    flash.mem[5][7] = ~flash.mem[5][7];
    flash.mem[9][33] = ~flash.mem[9][33];
    host_read(5, d, u);
    check("rd_fix_data_bit", d, pat(5));
    host_read(9, d, u);
    check("rd_fix_chk_bit", {u, d}, {1'b0, pat(9)});
    // Data bits 2 and 26 give a syndrome past the last code position.
    flash.mem[6] = flash.mem[6] ^ 38'h00_0400_0004;
    host_read(6, d, u);
    check("rd_double_unc", {u, d}, {1'b1, 32'h0000_0000});
    flash.mem[6] = flash.mem[6] ^ 38'h00_0400_0004;
  endtask : t_ecc

  task automatic t_boots();
    boot(rsum(0, 3), ~rsum(4, 7), rsum(8, 11));
    check("cfgbad_run", run_o, 1'b1);
    check("cfgbad_status", status_o, 4'h1);
    check("cfgbad_alert", host_alert_out_n_o, 1'b0);
    check("cfgbad_default", cfg_val_o, CFG_DFLT);
    boot(rsum(0, 3), rsum(4, 7), ~rsum(8, 11));
    check("logbad_status", status_o, 4'h4);
    boot(rsum(0, 3), rsum(4, 7), rsum(8, 11));
    check("good_run", run_o, 1'b1);
    check("good_status", {host_alert_out_n_o, status_o}, 5'h10);
    check("good_pins", {gpio_oe_o, fast_pulse_output_o}, {gpio_oe_req_i, fast_pulse_req_i});
    check("good_cfg_loaded", cfg_val_o, 8'(pat(4)));
  endtask : t_boots

  task automatic t_cfg_range();
    logic [CFG_W-1:0] vals [6] = '{8'h00, 8'h01, 8'hc8, 8'hc9, 8'hff, 8'h37};
    logic [CFG_W-1:0] kept;
    logic             rej;
    kept = cfg_val_o;
    for (int i = 0; i < 6; i++) begin
      cfg_wr_i = 1'b1;
      cfg_val_i = vals[i];
      rej = (vals[i] < CFG_MIN) || (vals[i] > CFG_MAX);
      kept = rej ? kept : vals[i];
      step(1);
      check("cfg_reject", cfg_reject_o, rej);
      check("cfg_value", cfg_val_o, kept);
    end
    cfg_wr_i = 1'b0;
  endtask : t_cfg_range

  task automatic t_watchdog();
    int n;
    wdog_kick_i = 1'b1;
    step(1);
    wdog_kick_i = 1'b0;
    n = 0;
    while (run_o === 1'b1 && n < WDOG_CYC + 100) begin
      step(1);
      n++;
    end
    check("wdog_expiry", (n > WDOG_CYC - 8) && (n < WDOG_CYC + 8), 1'b1);
    check("wdog_pins", {gpio_oe_o, fast_pulse_output_o}, '0);
    check("wdog_cfg_init", cfg_val_o, CFG_DFLT);
    n = 0;
    while (run_o !== 1'b1 && n < 500) begin
      step(1);
      n++;
    end
    check("wdog_rescan", {run_o, status_o}, 5'h10);
    check("wdog_cfg_reload", cfg_val_o, 8'(pat(4)));
  endtask : t_watchdog

  initial begin
    reset_n_i = 1'b0;
    host_wr_i = 1'b0;
    cfg_wr_i = 1'b0;
    wdog_kick_i = 1'b0;
    host_addr_i = '0;
    host_wdata_i = '0;
    cfg_val_i = '0;
    prog_sum_i = '0;
    cfg_sum_i = '0;
    log_sum_i = '0;
    gpio_oe_req_i = 26'h2aaaaaa;
    fast_pulse_req_i = 12'ha5c;
    t_halt();
    t_ecc();
    t_boots();
    t_cfg_range();
    t_watchdog();
    print_verdict();
  end
endmodule : tb
